// ==== rtl/aux_period_timer.sv ====
`timescale 1ns/10ps
`include "gate_consts.svh"
module aux_period_timer #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             reset_n,
   input  wire logic             aux_inc,
   input  wire logic [WIDTH-1:0] aux_period,
   output logic      [WIDTH-1:0] aux_timer_count,
   output logic                  match_pulse
);
   wire logic at_period;
   assign at_period = (aux_timer_count == aux_period);
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         aux_timer_count <= '0;
         match_pulse     <= 1'b0;
      end else begin
         match_pulse <= aux_inc && at_period;
         if (aux_inc) begin
            aux_timer_count <= at_period ? WIDTH'(`AUX_ZERO)
                                         : aux_timer_count + 1'b1;
         end
      end
   end
   AST_RESET_ON_MATCH: assert property (@(posedge clk_sys) disable iff (!reset_n)
      aux_inc && at_period |=> aux_timer_count == '0)
      else $error("aux timer did not clear after match");
   AST_PULSE_ONE_CYCLE: assert property (@(posedge clk_sys) disable iff (!reset_n)
      $rose(match_pulse) |=> !match_pulse || $past(aux_inc && at_period))
      else $error("match pulse too long");
endmodule // aux_period_timer

// ==== rtl/gate_consts.svh ====
// Overview of operation
// - Two-bit source field in control bits 1:0 picks one of four gate sources.
// - Code 00 pin, 01 aux match pulse, 10 comparator one, 11 comparator two.
// - Polarity bit 6 of the control register applies to the chosen source.
// - Pin source passes the external pin level into the gate logic.
// - Aux timer counts up to its period, then clears to zero next increment.
// - Each aux rollover makes a gate pulse high for exactly one cycle.
// - Match source, polarity 1: timer counts only the cycle after a match.
// - Match source, polarity 0: timer counts every cycle except after a match.
// - Comparator one source follows comparator status bit 6 transitions.
// - Comparator two source follows comparator status bit 7 transitions.
// - Toggle mode flip-flop inverts on each rising gate edge, measuring a period.
// - Toggle mode is enabled by control register bit 5.
// - With toggle disabled the toggle flip-flop is cleared and held clear.
// - Gate value flag shows the final gate level one cycle later, whether or not timer_on lets the timer count.
`ifndef GATE_CONSTS_SVH
`define GATE_CONSTS_SVH
`define GATE_SRC_LSB      0
`define GATE_SRC_MSB      1
`define GATE_TOGGLE_BIT   5
`define GATE_POL_BIT      6
`define CMP_ONE_BIT       6
`define CMP_TWO_BIT       7
`define SRC_PIN           2'h0
`define SRC_AUX           2'h1
`define SRC_CMP1          2'h2
`define SRC_CMP2          2'h3
`define AUX_ZERO          8'h00
`define TIMER_ZERO        16'h0000
`endif

// ==== rtl/gate_pkg.sv ====
package gate_pkg;
   typedef struct packed {
      logic       polarity;
      logic       toggle_en;
      logic [1:0] source;
   } gate_cfg_t;
endpackage

// ==== rtl/gate_toggle.sv ====
`timescale 1ns/10ps
module gate_toggle (
   input  wire logic clk_sys,
   input  wire logic reset_n,
   input  wire logic toggle_en,
   input  wire logic gate_in,
   output logic      gate_out
);
   logic gate_prev_r;
   logic toggle_r;
   wire logic rise;
   assign rise     = gate_in && !gate_prev_r;
   assign gate_out = toggle_en ? toggle_r : gate_in;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         gate_prev_r <= 1'b0;
         toggle_r    <= 1'b0;
      end else begin
         gate_prev_r <= gate_in;
         if (!toggle_en) begin
            toggle_r <= 1'b0;
         end else if (rise) begin
            toggle_r <= !toggle_r;
         end
      end
   end
   AST_TOGGLE_HELD: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !toggle_en |=> !toggle_r)
      else $error("toggle flop not held clear");
   AST_TOGGLE_FLIP: assert property (@(posedge clk_sys) disable iff (!reset_n)
      toggle_en && rise |=> toggle_r != $past(toggle_r) || !toggle_en)
      else $error("toggle flop did not invert");
endmodule // gate_toggle

// ==== rtl/timer_gate_source_toggle.sv ====
`timescale 1ns/10ps
`include "gate_consts.svh"
module timer_gate_source_toggle #(
   parameter int TWIDTH = 16,
   parameter int AWIDTH = 8
) (
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   input  wire logic [7:0]        gate_control_reg,
   input  wire logic              gate_control_we,
   input  wire logic [7:0]        comparator_status_reg,
   input  wire logic              external_gate_pin,
   input  wire logic              aux_inc,
   input  wire logic [AWIDTH-1:0] aux_period,
   input  wire logic              timer_on,
   output logic      [TWIDTH-1:0] gated_timer,
   output logic      [AWIDTH-1:0] aux_timer_count,
   output logic                   gate_value_flag,
   output gate_pkg::gate_cfg_t    gate_cfg
);
   gate_pkg::gate_cfg_t cfg_r;
   logic pin_meta_r;
   logic pin_sync_r;
   logic cmp1_meta_r;
   logic cmp1_sync_r;
   logic cmp2_meta_r;
   logic cmp2_sync_r;
   logic gate_val_r;
   wire logic match_pulse;
   wire logic src_raw;
   wire logic src_pol;
   wire logic gate_final;
   wire logic count_en;
   wire logic sel_pin;
   wire logic sel_aux;
   wire logic sel_cmp1;
   wire logic sel_cmp2;

   // Configuration capture
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cfg_r <= '0;
      end else if (gate_control_we) begin
         cfg_r.source    <= gate_control_reg[`GATE_SRC_MSB:`GATE_SRC_LSB];
         cfg_r.polarity  <= gate_control_reg[`GATE_POL_BIT];
         cfg_r.toggle_en <= gate_control_reg[`GATE_TOGGLE_BIT];
      end
   end
   assign gate_cfg = cfg_r;

   // Synchronisers for asynchronous sources
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pin_meta_r  <= 1'b0;
         pin_sync_r  <= 1'b0;
         cmp1_meta_r <= 1'b0;
         cmp1_sync_r <= 1'b0;
         cmp2_meta_r <= 1'b0;
         cmp2_sync_r <= 1'b0;
      end else begin
         pin_meta_r  <= external_gate_pin;
         pin_sync_r  <= pin_meta_r;
         cmp1_meta_r <= comparator_status_reg[`CMP_ONE_BIT];
         cmp1_sync_r <= cmp1_meta_r;
         cmp2_meta_r <= comparator_status_reg[`CMP_TWO_BIT];
         cmp2_sync_r <= cmp2_meta_r;
      end
   end

   aux_period_timer #(
      .WIDTH(AWIDTH)
   ) u_aux (
      .clk_sys         (clk_sys),
      .reset_n         (reset_n),
      .aux_inc         (aux_inc),
      .aux_period      (aux_period),
      .aux_timer_count (aux_timer_count),
      .match_pulse     (match_pulse)
   );

   // Source code decode
   function automatic logic src_is(input logic [1:0] sel, input logic [1:0] code);
      return (sel == code);
   endfunction

   assign sel_pin  = src_is(cfg_r.source, `SRC_PIN);
   assign sel_aux  = src_is(cfg_r.source, `SRC_AUX);
   assign sel_cmp1 = src_is(cfg_r.source, `SRC_CMP1);
   assign sel_cmp2 = src_is(cfg_r.source, `SRC_CMP2);

   // Source selection
   assign src_raw = sel_pin  ? pin_sync_r :
                    sel_aux  ? match_pulse :
                    sel_cmp1 ? cmp1_sync_r :
                               cmp2_sync_r;
   assign src_pol = cfg_r.polarity ? src_raw : !src_raw;

   gate_toggle u_toggle (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .toggle_en (cfg_r.toggle_en),
      .gate_in   (src_pol),
      .gate_out  (gate_final)
   );

   assign count_en = timer_on && gate_final;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         gated_timer <= TWIDTH'(`TIMER_ZERO);
         gate_val_r  <= 1'b0;
      end else begin
         gate_val_r <= gate_final;
         if (count_en) begin
            gated_timer <= gated_timer + 1'b1;
         end
      end
   end
   assign gate_value_flag = gate_val_r;

   // Counting checks
   AST_COUNT_ONLY_GATED: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !count_en |=> $stable(gated_timer))
      else $error("timer moved with gate inactive");

   AST_COUNT_WHEN_GATED: assert property (@(posedge clk_sys) disable iff (!reset_n)
      count_en |=> gated_timer == $past(gated_timer) + 1'b1)
      else $error("timer did not advance");

   AST_TIMER_OFF: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !timer_on
      |=> $stable(gated_timer))
      else $error("timer moved while switched off");

   AST_PIN_COUNT: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sel_pin && cfg_r.polarity && !cfg_r.toggle_en && timer_on && pin_sync_r
      |=> gated_timer == $past(gated_timer) + 1'b1)
      else $error("pin gate did not count");

   AST_CMP1_COUNT: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sel_cmp1 && cfg_r.polarity && !cfg_r.toggle_en && timer_on && cmp1_sync_r
      |=> gated_timer == $past(gated_timer) + 1'b1)
      else $error("comparator one gate did not count");

   AST_CMP2_COUNT: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sel_cmp2 && cfg_r.polarity && !cfg_r.toggle_en && timer_on && cmp2_sync_r
      |=> gated_timer == $past(gated_timer) + 1'b1)
      else $error("comparator two gate did not count");

   AST_MATCH_COUNT: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sel_aux && cfg_r.polarity && !cfg_r.toggle_en && timer_on && match_pulse
      |=> gated_timer == $past(gated_timer) + 1'b1)
      else $error("timer missed the match cycle");

   AST_MATCH_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sel_aux && !cfg_r.polarity && !cfg_r.toggle_en && match_pulse
      |=> $stable(gated_timer))
      else $error("timer counted in the match cycle");

   // Gate value flag
   AST_FLAG_FOLLOWS: assert property (@(posedge clk_sys) disable iff (!reset_n)
      1'b1 |=> gate_value_flag == $past(gate_final))
      else $error("gate value flag wrong");

   AST_FLAG_HIGH: assert property (@(posedge clk_sys) disable iff (!reset_n)
      gate_final
      |=> gate_value_flag)
      else $error("gate value flag not set");

   AST_FLAG_LOW: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !gate_final
      |=> !gate_value_flag)
      else $error("gate value flag not clear");

   // Match pulse path
   AST_MATCH_POL1: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sel_aux && cfg_r.polarity && !cfg_r.toggle_en
      |-> gate_final == match_pulse)
      else $error("match gate polarity one wrong");

   AST_MATCH_POL0: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sel_aux && !cfg_r.polarity && !cfg_r.toggle_en
      |-> gate_final == !match_pulse)
      else $error("match gate polarity zero wrong");

   AST_AUX_PULSE: assert property (@(posedge clk_sys) disable iff (!reset_n)
      aux_inc && aux_timer_count == aux_period
      |=> match_pulse)
      else $error("match pulse missing after rollover");

   AST_AUX_NO_PULSE: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !(aux_inc && aux_timer_count == aux_period)
      |=> !match_pulse)
      else $error("match pulse without rollover");

   // Source and polarity paths
   AST_PIN_PATH: assert property (@(posedge clk_sys) disable iff (!reset_n)
      cfg_r.source == `SRC_PIN && cfg_r.polarity |-> src_raw == pin_sync_r)
      else $error("pin source not routed");

   AST_SEL_PIN: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sel_pin
      |-> src_raw == pin_sync_r)
      else $error("pin source not selected");

   AST_SEL_AUX: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sel_aux
      |-> src_raw == match_pulse)
      else $error("match pulse source not selected");

   AST_SEL_CMP1: assert property (@(posedge clk_sys) disable iff (!reset_n)
      sel_cmp1
      |-> src_raw == cmp1_sync_r)
      else $error("comparator one not routed");

   AST_CMP_PATH: assert property (@(posedge clk_sys) disable iff (!reset_n)
      cfg_r.source == `SRC_CMP2 |-> src_raw == cmp2_sync_r)
      else $error("comparator two not routed");

   AST_SEL_ONEHOT: assert property (@(posedge clk_sys) disable iff (!reset_n)
      1'b1
      |-> $onehot({sel_pin, sel_aux, sel_cmp1, sel_cmp2}))
      else $error("source decode not one-hot");

   AST_POL_HIGH: assert property (@(posedge clk_sys) disable iff (!reset_n)
      cfg_r.polarity
      |-> src_pol == src_raw)
      else $error("polarity one altered the source");

   AST_POL_LOW: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !cfg_r.polarity
      |-> src_pol != src_raw)
      else $error("polarity zero did not invert");

   AST_ROUTE_DIRECT: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !cfg_r.toggle_en
      |-> gate_final == src_pol)
      else $error("gate not direct with toggle off");

   AST_TOGGLE_START: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !cfg_r.toggle_en ##1 cfg_r.toggle_en
      |-> !gate_final)
      else $error("toggle mode did not start clear");

   // Synchroniser stages
   AST_PIN_META: assert property (@(posedge clk_sys) disable iff (!reset_n)
      1'b1
      |=> pin_meta_r == $past(external_gate_pin))
      else $error("pin first stage wrong");

   AST_PIN_SYNC: assert property (@(posedge clk_sys) disable iff (!reset_n)
      1'b1
      |=> pin_sync_r == $past(pin_meta_r))
      else $error("pin second stage wrong");

   AST_CMP1_SYNC: assert property (@(posedge clk_sys) disable iff (!reset_n)
      1'b1
      |=> cmp1_sync_r == $past(cmp1_meta_r))
      else $error("comparator one stage wrong");

   AST_CMP2_SYNC: assert property (@(posedge clk_sys) disable iff (!reset_n)
      1'b1
      |=> cmp2_sync_r == $past(cmp2_meta_r))
      else $error("comparator two stage wrong");

   // Configuration load and hold
   AST_CFG_LOAD: assert property (@(posedge clk_sys) disable iff (!reset_n)
      gate_control_we |=> cfg_r.source == $past(gate_control_reg[1:0]))
      else $error("source select not loaded");

   AST_CFG_POL_LOAD: assert property (@(posedge clk_sys) disable iff (!reset_n)
      gate_control_we
      |=> cfg_r.polarity == $past(gate_control_reg[`GATE_POL_BIT]))
      else $error("polarity not loaded");

   AST_CFG_TOG_LOAD: assert property (@(posedge clk_sys) disable iff (!reset_n)
      gate_control_we
      |=> cfg_r.toggle_en == $past(gate_control_reg[`GATE_TOGGLE_BIT]))
      else $error("toggle enable not loaded");

   AST_CFG_HOLD: assert property (@(posedge clk_sys) disable iff (!reset_n)
      !gate_control_we
      |=> $stable(cfg_r))
      else $error("configuration changed without write");

   // Coverage
   COV_AUX_COUNT: cover property (@(posedge clk_sys) disable iff (!reset_n)
      cfg_r.source == `SRC_AUX && count_en);

   COV_AUX_POL0: cover property (@(posedge clk_sys) disable iff (!reset_n)
      sel_aux && !cfg_r.polarity && count_en);

   COV_TOGGLE: cover property (@(posedge clk_sys) disable iff (!reset_n)
      cfg_r.toggle_en && $rose(gate_final));

   COV_CMP1: cover property (@(posedge clk_sys) disable iff (!reset_n)
      cfg_r.source == `SRC_CMP1 && count_en);

   COV_CMP2: cover property (@(posedge clk_sys) disable iff (!reset_n)
      sel_cmp2 && count_en);
endmodule // timer_gate_source_toggle

// ==== testbench/gate_source_model.sv ====
`timescale 1ns/10ps
module gate_source_model (
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic       pin_level,
   input  wire logic       pulse_mode,
   input  wire logic [1:0] cmp_levels,
   output logic            external_gate_pin,
   output logic [7:0]      comparator_status_reg,
   output logic            aux_inc
);
   logic [3:0] cnt_r;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= (cnt_r == 4'h9) ? 4'h0 : cnt_r + 4'h1;
      end
   end
   // Level, or one-cycle pulse every ten cycles
   assign external_gate_pin     = pulse_mode ? (cnt_r == 4'h0) : pin_level;
   assign comparator_status_reg = {cmp_levels, 6'h00};
   assign aux_inc               = reset_n;
endmodule // gate_source_model

// ==== testbench/timer_gate_source_toggle_tb.sv ====
`timescale 1ns/10ps
module timer_gate_source_toggle_tb;
   logic                clk_sys;
   logic                reset_n;
   logic [7:0]          ctrl;
   logic                we;
   logic                pin_level;
   logic                pulse_mode;
   logic                timer_on;
   logic [1:0]          cmp_levels;
   logic                ext_pin;
   logic                aux_inc;
   logic [7:0]          cmp_stat;
   logic [7:0]          aux_period;
   logic [7:0]          aux_count;
   logic [15:0]         gated_timer;
   logic [15:0]         t0;
   logic                flag;
   gate_pkg::gate_cfg_t cfg;
   int                  n_fail;
   int                  tests_run;

   gate_source_model i_src (.clk_sys(clk_sys), .reset_n(reset_n), .pin_level(pin_level),
      .pulse_mode(pulse_mode), .cmp_levels(cmp_levels), .external_gate_pin(ext_pin),
      .comparator_status_reg(cmp_stat), .aux_inc(aux_inc));
   timer_gate_source_toggle i_dut (.clk_sys(clk_sys), .reset_n(reset_n),
      .gate_control_reg(ctrl), .gate_control_we(we), .comparator_status_reg(cmp_stat),
      .external_gate_pin(ext_pin), .aux_inc(aux_inc), .aux_period(aux_period),
      .timer_on(timer_on), .gated_timer(gated_timer), .aux_timer_count(aux_count),
      .gate_value_flag(flag), .gate_cfg(cfg));

   always #10 clk_sys = ~clk_sys;

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic write_cfg(input logic [1:0] src, input logic tog, input logic pol);
      @(posedge clk_sys);
      ctrl <= {1'b0, pol, tog, 3'h0, src};
      we   <= 1'b1;
      @(posedge clk_sys);
      we <= 1'b0;
      #1;
      check("gate_cfg", {12'h000, cfg}, {12'h000, pol, tog, src});
   endtask
   task automatic count_over(input string what, input int n, input logic [15:0] exp);
      repeat (6) @(posedge clk_sys);
      #1;
      t0 = gated_timer;
      repeat (n) @(posedge clk_sys);
      #1;
      check(what, gated_timer - t0, exp);
   endtask
   task automatic sc_reset;
      #1;
      check("timer at reset", gated_timer, 16'h0000);
      check("cfg at reset", {12'h000, cfg}, 16'h0000);
   endtask
   task automatic sc_aux;
      logic [7:0] prev;
      logic [7:0] exp_cnt;
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         #1;
         prev    = aux_count;
         exp_cnt = (prev == aux_period) ? 8'h00 : prev + 8'h01;
         @(posedge clk_sys);
         #1;
         check("aux count", {8'h00, aux_count}, {8'h00, exp_cnt});
      end
      write_cfg(2'h1, 1'b0, 1'b1);
      count_over("aux pol1", 40, 16'h000A);
      write_cfg(2'h1, 1'b0, 1'b0);
      count_over("aux pol0", 40, 16'h001E);
   endtask
   task automatic sc_pin;
      write_cfg(2'h0, 1'b0, 1'b1);
      pin_level <= 1'b1;
      count_over("pin high", 20, 16'h0014);
      check("flag high", {15'h0000, flag}, 16'h0001);
      pin_level <= 1'b0;
      count_over("pin low", 20, 16'h0000);
      check("flag low", {15'h0000, flag}, 16'h0000);
      write_cfg(2'h0, 1'b0, 1'b0);
      count_over("pin low pol0", 20, 16'h0014);
      timer_on <= 1'b0;
      count_over("timer off", 20, 16'h0000);
      timer_on <= 1'b1;
   endtask
   task automatic sc_cmp;
      cmp_levels <= 2'h1;
      write_cfg(2'h2, 1'b0, 1'b1);
      count_over("cmp one high", 20, 16'h0014);
      write_cfg(2'h3, 1'b0, 1'b1);
      count_over("cmp two low", 20, 16'h0000);
      cmp_levels <= 2'h2;
      count_over("cmp two high", 20, 16'h0014);
      write_cfg(2'h2, 1'b0, 1'b1);
      count_over("cmp one low", 20, 16'h0000);
   endtask
   task automatic sc_toggle;
      pulse_mode <= 1'b1;
      write_cfg(2'h0, 1'b1, 1'b1);
      count_over("toggle period", 40, 16'h0014);
      pulse_mode <= 1'b0;
      write_cfg(2'h0, 1'b0, 1'b1);
      write_cfg(2'h0, 1'b1, 1'b1);
      count_over("toggle cleared", 20, 16'h0000);
   endtask
   task automatic report_and_stop;
      $display("n_fail %0d tests_run %0d", n_fail, tests_run);
      if (n_fail == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   initial begin
      clk_sys    = 1'b0;
      reset_n    = 1'b0;
      ctrl       = 8'h00;
      we         = 1'b0;
      pin_level  = 1'b0;
      pulse_mode = 1'b0;
      timer_on   = 1'b1;
      cmp_levels = 2'h0;
      aux_period = 8'h03;
      n_fail     = 0;
      tests_run  = 0;
      repeat (16) @(posedge clk_sys);
      sc_reset();
      @(posedge clk_sys);
      reset_n <= 1'b1;
      sc_aux();
      sc_pin();
      sc_cmp();
      sc_toggle();
      report_and_stop();
   end
   initial begin
      #100000;
      n_fail++;
      report_and_stop();
   end
endmodule // timer_gate_source_toggle_tb
